// *** core/sci_ctrl.sv ***
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
// Function
// - Command register write starts a command on the selected drive; busy rises.
// - Opcode 000 runs Identify, 001 runs Shutdown.
// - Opcode 010 is Write, 011 is Read, using address, length, pattern.
// - Opcode 100 is SMART, 110 is Flush, using the submission entry.
// - Status bit 0 is busy, cleared when the command finishes.
// - Error sets status bit 1, drive in bits 25:24, detail in error type.
// - Read verification failure sets status bit 2; transfer keeps running.
// - Identify data lands in the identify data RAM for software.
// - SMART log data lands in the custom data RAM for software.
// - Status bits 19:16 count active drives, updated after shutdown.
// - Link status shows link-up in bit 0, lanes and speed in 7:2.
// - Busy held high through initialization after link-up; software waits.
// - Shutdown deactivates the drive; no active drive makes controller inactive.
// - Running byte count of Write or Read is readable.
// - First failing Read byte address captured as 57 bits, low and high.
module sci_ctrl
  import sci_pkg::*;
#(
  parameter int IDEN_WORDS = 1024,
  parameter int CTM_WORDS  = 128
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output sci_cmd_t         cmd,
  input  wire sci_eng_t    eng,
  input  wire sci_link_t   link,
  input  wire sci_ram_wr_t ram
);

  localparam int IW = $clog2(IDEN_WORDS);
  localparam int CW = $clog2(CTM_WORDS);

  if (IDEN_WORDS > 1024 || CTM_WORDS > 2048 || IDEN_WORDS < 2 || CTM_WORDS < 2 ||
      (1 << IW) != IDEN_WORDS || (1 << CW) != CTM_WORDS)
  begin : g_bad
    $error("sci_ctrl: RAM depths must be powers of two within their windows");
  end

  typedef struct packed {
    sci_state_t                  st;
    logic [31:0]                 adr_lo;
    logic [31:0]                 adr_hi;
    logic [31:0]                 len_lo;
    logic [31:0]                 len_hi;
    logic [2:0]                  patt;
    logic [2:0]                  op;
    logic [1:0]                  drv;
    logic                        req;
    logic                        busy;
    logic                        err;
    logic                        vfail;
    logic [1:0]                  err_drv;
    logic [31:0]                 err_type;
    logic [56:0]                 fail_adr;
    logic [56:0]                 cur_size;
    logic [3:0]                  active;
    logic [SUBM_WORDS-1:0][31:0] subm;
    logic [IDEN_WORDS-1:0][31:0] iden;
    logic [CTM_WORDS-1:0][31:0]  ctm;
    logic [31:0]                 prdata;
  } sci_regs_t;

  sci_regs_t r_reg;
  sci_regs_t r_next;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic          wr_acc;
  logic          rd_setup;
  logic          in_subm;
  logic          in_iden;
  logic          in_ctm;
  logic          mapped;
  logic          cmd_acc;
  logic [2:0]    acc_op;
  logic [1:0]    acc_drv;
  logic          op_legal;
  logic [2:0]    active_cnt;
  logic [IW-1:0] ram_ix;

  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign in_subm  = paddr[15:6] == OFF_SUBM[15:6];
  assign in_iden  = paddr[15:12] == OFF_IDEN[15:12] && {1'b0, paddr[11:2]} < 11'(IDEN_WORDS);
  assign in_ctm   = paddr[15:13] == OFF_CTM[15:13] && {1'b0, paddr[12:2]} < 12'(CTM_WORDS);
  assign acc_op   = pwdata[2:0];
  assign acc_drv  = pwdata[CMD_DRV_LSB +: 2];
  assign ram_ix   = ram.addr[IW-1:0];
  assign op_legal = acc_op inside {OP_IDENTIFY, OP_SHUTDOWN, OP_WRITE, OP_READ,
                                   OP_SMART, OP_FLUSH};
  assign cmd_acc  = wr_acc && paddr == OFF_CMD && r_reg.st == ST_IDLE && !r_reg.busy &&
                    op_legal && r_reg.active[acc_drv];

  always_comb
  begin
    unique case (paddr)
      OFF_ADR_LO, OFF_ADR_HI, OFF_LEN_LO, OFF_LEN_HI, OFF_CMD, OFF_PATT, OFF_STS,
      OFF_ERRTYPE, OFF_LINK, OFF_FAIL_LO, OFF_FAIL_HI, OFF_SIZE_LO, OFF_SIZE_HI:
        mapped = 1'b1;
      default:
        mapped = in_subm || in_iden || in_ctm;
    endcase
  end

  always_comb
  begin
    active_cnt = 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      active_cnt = active_cnt + 3'(r_reg.active[i]);
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = r_reg.prdata;

  assign cmd.valid = r_reg.req;
  assign cmd.op    = r_reg.op;
  assign cmd.drv   = r_reg.drv;
  assign cmd.addr  = {r_reg.adr_hi, r_reg.adr_lo};
  assign cmd.len   = {r_reg.len_hi, r_reg.len_lo};
  assign cmd.patt  = r_reg.patt;
  assign cmd.subm  = r_reg.subm;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next     = r_reg;
    r_next.req = 1'b0;

    // Register reads
    if (rd_setup)
    begin
      r_next.prdata = 32'h0;
      unique case (paddr)
        OFF_ADR_LO:  r_next.prdata = r_reg.adr_lo;
        OFF_ADR_HI:  r_next.prdata = r_reg.adr_hi;
        OFF_LEN_LO:  r_next.prdata = r_reg.len_lo;
        OFF_LEN_HI:  r_next.prdata = r_reg.len_hi;
        OFF_PATT:    r_next.prdata = {29'h0, r_reg.patt};
        OFF_STS:
        begin
          r_next.prdata[STS_BUSY]          = r_reg.busy;
          r_next.prdata[STS_ERR]           = r_reg.err;
          r_next.prdata[STS_VFAIL]         = r_reg.vfail;
          r_next.prdata[STS_CNT_LSB +: 4]  = {1'b0, active_cnt};
          r_next.prdata[STS_DRV_LSB +: 2]  = r_reg.err_drv;
        end
        OFF_ERRTYPE: r_next.prdata = r_reg.err_type;
        OFF_LINK:    r_next.prdata = {24'h0, link.spd, 1'b0, link.up};
        OFF_FAIL_LO: r_next.prdata = r_reg.fail_adr[31:0];
        OFF_FAIL_HI: r_next.prdata = {7'h0, r_reg.fail_adr[56:32]};
        OFF_SIZE_LO: r_next.prdata = r_reg.cur_size[31:0];
        OFF_SIZE_HI: r_next.prdata = {7'h0, r_reg.cur_size[56:32]};
        default:
        begin
          if (in_subm)
            r_next.prdata = r_reg.subm[paddr[5:2]];
          else if (in_iden)
            r_next.prdata = r_reg.iden[paddr[IW+1:2]];
          else if (in_ctm)
            r_next.prdata = r_reg.ctm[paddr[CW+1:2]];
        end
      endcase
    end

    // Register writes
    if (wr_acc)
    begin
      unique case (paddr)
        OFF_ADR_LO: r_next.adr_lo = pwdata;
        OFF_ADR_HI: r_next.adr_hi = pwdata;
        OFF_LEN_LO: r_next.len_lo = pwdata;
        OFF_LEN_HI: r_next.len_hi = pwdata;
        OFF_PATT:   r_next.patt   = pwdata[2:0];
        default:
        begin
          if (in_subm)
            r_next.subm[paddr[5:2]] = pwdata;
          else if (in_ctm)
            r_next.ctm[paddr[CW+1:2]] = pwdata;
        end
      endcase
    end

    // Result data from the engine
    if (ram.iden_we)
      r_next.iden[ram_ix] = ram.data;
    if (ram.ctm_we)
      r_next.ctm[ram.addr[CW-1:0]] = ram.data;

    // Sequencer
    unique case (r_reg.st)
      ST_LINKWAIT:
      begin
        if (link.up)
          r_next.st = ST_INIT;
      end
      ST_INIT:
      begin
        if (eng.err)
        begin
          r_next.err      = 1'b1;
          r_next.err_type = eng.err_type;
        end
        if (link.init_done)
        begin
          r_next.busy   = 1'b0;
          r_next.active = link.present;
          r_next.st     = (link.present == 4'h0) ? ST_INACTIVE : ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (cmd_acc)
        begin
          r_next.op    = acc_op;
          r_next.drv   = acc_drv;
          r_next.req   = 1'b1;
          r_next.busy  = 1'b1;
          r_next.err   = 1'b0;
          r_next.vfail = 1'b0;
          r_next.st    = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (r_reg.op == OP_WRITE || r_reg.op == OP_READ)
          r_next.cur_size = eng.xfer_bytes;
        if (eng.vfail && r_reg.op == OP_READ)
        begin
          r_next.vfail = 1'b1;
          if (!r_reg.vfail)
            r_next.fail_adr = eng.vfail_adr;
        end
        if (eng.err)
        begin
          r_next.err      = 1'b1;
          r_next.err_drv  = r_reg.drv;
          r_next.err_type = eng.err_type;
          r_next.busy     = 1'b0;
          r_next.st       = ST_IDLE;
        end
        else if (eng.done)
        begin
          r_next.busy = 1'b0;
          r_next.st   = ST_IDLE;
          if (r_reg.op == OP_SHUTDOWN)
          begin
            r_next.active[r_reg.drv] = 1'b0;
            if ((r_reg.active & ~(4'h1 << r_reg.drv)) == 4'h0)
              r_next.st = ST_INACTIVE;
          end
        end
      end
      ST_INACTIVE:
      begin
        r_next.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg      <= '0;
      r_reg.st   <= ST_LINKWAIT;
      r_reg.busy <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  busy_rise_a: assert property (cmd_acc |=> r_reg.busy && cmd.valid ##1 !cmd.valid)
    else $error("busy or request did not follow command write");
  op_decode_a: assert property (cmd_acc |=> cmd.op == $past(acc_op) && cmd.drv == $past(acc_drv))
    else $error("opcode or drive not latched");
  param_hold_a: assert property (r_reg.st == ST_RUN |-> $stable(cmd.addr) && $stable(cmd.len))
    else $error("transfer parameters changed mid-command");
  busy_clear_a: assert property (r_reg.st == ST_RUN && eng.done |=> !r_reg.busy && r_reg.st != ST_RUN)
    else $error("busy not cleared on completion");
  err_report_a: assert property (r_reg.st == ST_RUN && eng.err |=>
      r_reg.err && r_reg.err_drv == $past(r_reg.drv) && r_reg.err_type == $past(eng.err_type))
    else $error("error not reported");
  vfail_keep_a: assert property (r_reg.st == ST_RUN && r_reg.op == OP_READ && eng.vfail &&
      !eng.done && !eng.err |=> r_reg.vfail && r_reg.busy && r_reg.st == ST_RUN)
    else $error("verification fail not flagged or transfer stopped");
  iden_store_a: assert property (ram.iden_we |=> r_reg.iden[$past(ram_ix)] == $past(ram.data))
    else $error("identify word not stored");
  count_drop_a: assert property (r_reg.st == ST_RUN && r_reg.op == OP_SHUTDOWN && eng.done &&
      !eng.err |=> active_cnt == $past(active_cnt) - 3'h1)
    else $error("active count not reduced after shutdown");
  init_busy_a: assert property (r_reg.st == ST_INIT || r_reg.st == ST_LINKWAIT |-> r_reg.busy)
    else $error("busy low during initialization");
  inactive_a: assert property (r_reg.st == ST_INACTIVE |=> r_reg.st == ST_INACTIVE && !cmd.valid)
    else $error("inactive controller took a command");
  size_track_a: assert property (r_reg.st == ST_RUN && r_reg.op == OP_WRITE |=>
      r_reg.cur_size == $past(eng.xfer_bytes))
    else $error("byte count not tracked");
  fail_first_a: assert property (r_reg.vfail && r_reg.st == ST_RUN |=> $stable(r_reg.fail_adr))
    else $error("first fail address overwritten");
  busy_ignore_a: assert property (wr_acc && paddr == OFF_CMD && r_reg.busy |=> !cmd.valid)
    else $error("command accepted while busy");

  identify_c: cover property (cmd_acc && acc_op == OP_IDENTIFY ##[1:50] eng.done);
  read_fail_c: cover property (r_reg.st == ST_RUN && r_reg.op == OP_READ && eng.vfail);
  last_down_c: cover property (r_reg.st == ST_RUN ##1 r_reg.st == ST_INACTIVE);
  error_c: cover property (r_reg.st == ST_RUN && eng.err);

endmodule : sci_ctrl

// *** core/sci_pkg.sv ***
package sci_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_ADR_LO   = 16'h0000;
  localparam logic [15:0] OFF_ADR_HI   = 16'h0004;
  localparam logic [15:0] OFF_LEN_LO   = 16'h0008;
  localparam logic [15:0] OFF_LEN_HI   = 16'h000c;
  localparam logic [15:0] OFF_CMD      = 16'h0010;
  localparam logic [15:0] OFF_PATT     = 16'h0014;
  localparam logic [15:0] OFF_STS      = 16'h0100;
  localparam logic [15:0] OFF_ERRTYPE  = 16'h0104;
  localparam logic [15:0] OFF_LINK     = 16'h0108;
  localparam logic [15:0] OFF_FAIL_LO  = 16'h0150;
  localparam logic [15:0] OFF_FAIL_HI  = 16'h0154;
  localparam logic [15:0] OFF_SIZE_LO  = 16'h0158;
  localparam logic [15:0] OFF_SIZE_HI  = 16'h015c;
  localparam logic [15:0] OFF_SUBM     = 16'h0200;
  localparam logic [15:0] OFF_IDEN     = 16'h2000;
  localparam logic [15:0] OFF_CTM      = 16'h4000;

  // ----------------------------------------------------------------
  // Field positions and sizes
  // ----------------------------------------------------------------
  localparam int STS_BUSY    = 0;
  localparam int STS_ERR     = 1;
  localparam int STS_VFAIL   = 2;
  localparam int STS_CNT_LSB = 16;
  localparam int STS_DRV_LSB = 24;
  localparam int LNK_UP      = 0;
  localparam int LNK_SPD_LSB = 2;
  localparam int CMD_DRV_LSB = 8;
  localparam int SUBM_WORDS  = 16;
  localparam int HI_BITS     = 25;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_IDENTIFY = 3'h0;
  localparam logic [2:0] OP_SHUTDOWN = 3'h1;
  localparam logic [2:0] OP_WRITE    = 3'h2;
  localparam logic [2:0] OP_READ     = 3'h3;
  localparam logic [2:0] OP_SMART    = 3'h4;
  localparam logic [2:0] OP_FLUSH    = 3'h6;

  typedef enum logic [2:0] {ST_LINKWAIT, ST_INIT, ST_IDLE, ST_RUN, ST_INACTIVE} sci_state_t;

  typedef struct packed {
    logic                        valid;
    logic [2:0]                  op;
    logic [1:0]                  drv;
    logic [63:0]                 addr;
    logic [63:0]                 len;
    logic [2:0]                  patt;
    logic [SUBM_WORDS-1:0][31:0] subm;
  } sci_cmd_t;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [31:0] err_type;
    logic        vfail;
    logic [56:0] vfail_adr;
    logic [56:0] xfer_bytes;
  } sci_eng_t;

  typedef struct packed {
    logic       up;
    logic [5:0] spd;
    logic       init_done;
    logic [3:0] present;
  } sci_link_t;

  typedef struct packed {
    logic        iden_we;
    logic        ctm_we;
    logic [10:0] addr;
    logic [31:0] data;
  } sci_ram_wr_t;

endpackage : sci_pkg

// *** verification/sci_drive_model.sv ***
`timescale 1ns/100ps
module sci_drive_model
  import sci_pkg::*;
#(
  parameter logic [31:0] IDEN_WORD = 32'h1dec_0001,
  parameter logic [31:0] CTM_WORD  = 32'h5a5a_0042,
  parameter logic [31:0] ERR_CODE  = 32'h0000_0100,
  parameter logic [56:0] FAIL_ADR  = {25'h0000012, 32'h0000_0040},
  parameter logic [5:0]  LINK_SPD  = 6'h0d
)(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire sci_cmd_t cmd,
  input  wire logic     err_req,
  output sci_eng_t      eng,
  output sci_link_t     link,
  output sci_ram_wr_t   ram
);
  logic [7:0] boot_reg;
  logic [3:0] cnt_reg;
  logic       run_reg;
  logic [2:0] op_reg;
  // ------------------------------------------------------------
  // Link bring-up
  // ------------------------------------------------------------
  assign link.up        = (boot_reg >= 8'h14);
  assign link.init_done = (boot_reg >= 8'h1e);
  assign link.present   = 4'h3;
  assign link.spd       = LINK_SPD;
  // ------------------------------------------------------------
  // Drive engine
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_reg <= 8'h00;
      cnt_reg  <= 4'h0;
      run_reg  <= 1'b0;
      op_reg   <= 3'h0;
      eng      <= '0;
      ram      <= '0;
    end
    else
    begin
      eng.done     <= 1'b0;
      eng.err      <= 1'b0;
      eng.vfail    <= 1'b0;
      ram.iden_we  <= 1'b0;
      ram.ctm_we   <= 1'b0;
      ram.data     <= ~ram.data;
      if (boot_reg != 8'hff)
        boot_reg <= boot_reg + 8'h01;
      if (cmd.valid)
      begin
        run_reg        <= 1'b1;
        cnt_reg        <= 4'h0;
        op_reg         <= cmd.op;
        eng.xfer_bytes <= '0;
      end
      else if (run_reg)
      begin
        cnt_reg <= cnt_reg + 4'h1;
        if (op_reg == OP_WRITE || op_reg == OP_READ)
          eng.xfer_bytes <= eng.xfer_bytes + 57'd512;
        if (cnt_reg == 4'h1 && op_reg == OP_IDENTIFY)
        begin
          ram.iden_we <= 1'b1;
          ram.addr    <= 11'h000;
          ram.data    <= IDEN_WORD;
        end
        if (cnt_reg == 4'h1 && op_reg == OP_SMART)
        begin
          ram.ctm_we <= 1'b1;
          ram.addr   <= 11'h000;
          ram.data   <= CTM_WORD;
        end
        if (cnt_reg == 4'h3 && op_reg == OP_READ)
        begin
          eng.vfail     <= 1'b1;
          eng.vfail_adr <= FAIL_ADR;
        end
        if (cnt_reg == 4'h7)
        begin
          run_reg <= 1'b0;
          if (err_req)
          begin
            eng.err      <= 1'b1;
            eng.err_type <= ERR_CODE;
          end
          else
            eng.done <= 1'b1;
        end
      end
    end
  end
endmodule : sci_drive_model

// *** verification/testbench.sv ***
`timescale 1ns/100ps
module testbench
  import sci_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_req;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic        e;
  sci_cmd_t    cmd, cap;
  sci_eng_t    eng;
  sci_link_t   link;
  sci_ram_wr_t ram;
  int          n_fail, n_compared, n_cmd, k;

  sci_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd(cmd), .eng(eng), .link(link), .ram(ram));
  sci_drive_model drv (.pclk(pclk), .presetn(presetn), .cmd(cmd), .err_req(err_req),
    .eng(eng), .link(link), .ram(ram));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (cmd.valid === 1'b1)
    begin
      n_cmd <= n_cmd + 1;
      cap   <= cmd;
    end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (i >= 50)
    begin
      n_fail++;
      finish_test();
    end
  endtask : apb

  task wait_idle;
    int i;
    i = 0;
    do
    begin
      apb(1'b0, OFF_STS, 32'h0);
      i++;
    end
    while (rd[STS_BUSY] !== 1'b0 && i < 200);
    st = rd;
    if (i >= 200)
    begin
      n_fail++;
      finish_test();
    end
  endtask : wait_idle

  task go(input logic [2:0] op, input logic [1:0] d);
    apb(1'b1, OFF_CMD, {22'h0, d, 5'h0, op});
  endtask : go
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0;
    err_req = 1'b0;
    n_fail  = 0;
    n_compared = 0;
    n_cmd   = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_STS, 32'h0);
    chk("init busy", 32'h1, {31'h0, rd[STS_BUSY]});
    wait_idle();
    chk("drive count", 32'h2, {28'h0, st[19:16]});
    apb(1'b0, OFF_LINK, 32'h0);
    chk("link", {24'h0, 6'h0d, 2'h1}, {24'h0, rd[7:2], 1'b0, rd[0]});
    $display("test boot done");

    go(OP_IDENTIFY, 2'h1);
    apb(1'b0, OFF_STS, 32'h0);
    chk("busy rise", 32'h1, {31'h0, rd[STS_BUSY]});
    wait_idle();
    chk("iden op", {27'h0, OP_IDENTIFY, 2'h1}, {27'h0, cap.op, cap.drv});
    apb(1'b0, OFF_IDEN, 32'h0);
    chk("iden ram", 32'h1dec_0001, rd);
    $display("test identify done");

    apb(1'b1, OFF_ADR_LO, 32'h0000_0008);
    apb(1'b1, OFF_ADR_HI, 32'h0000_0001);
    apb(1'b1, OFF_LEN_LO, 32'h0000_0010);
    apb(1'b1, OFF_LEN_HI, 32'h0);
    apb(1'b1, OFF_PATT, 32'h0000_0003);
    k = n_cmd;
    go(OP_WRITE, 2'h0);
    go(OP_SHUTDOWN, 2'h0);
    wait_idle();
    chk("busy cmds", k + 1, n_cmd);
    chk("write op", {29'h0, OP_WRITE}, {29'h0, cap.op});
    chk("addr", 32'h1, cap.addr[63:32]);
    chk("addr lo", 32'h8, cap.addr[31:0]);
    chk("len", 32'h10, cap.len[31:0]);
    chk("patt", 32'h3, {29'h0, cap.patt});
    apb(1'b0, OFF_SIZE_LO, 32'h0);
    chk("size", 32'd4096, rd);
    $display("test write done");

    go(OP_READ, 2'h0);
    wait_idle();
    chk("vfail", 32'h4, {29'h0, st[2:0]});
    apb(1'b0, OFF_FAIL_LO, 32'h0);
    chk("fail lo", 32'h0000_0040, rd);
    apb(1'b0, OFF_FAIL_HI, 32'h0);
    chk("fail hi", 32'h0000_0012, rd);
    $display("test read done");

    for (int j = 0; j < SUBM_WORDS; j++)
      apb(1'b1, OFF_SUBM + 16'(4 * j), 32'hc000_0000 + 32'(j));
    go(OP_SMART, 2'h1);
    wait_idle();
    chk("subm", 32'hc000_000f, cap.subm[15]);
    chk("smart sts", 32'h0, {29'h0, st[2:0]});
    apb(1'b0, OFF_CTM, 32'h0);
    chk("ctm ram", 32'h5a5a_0042, rd);
    go(OP_FLUSH, 2'h0);
    wait_idle();
    chk("flush op", {29'h0, OP_FLUSH}, {29'h0, cap.op});
    k = n_cmd;
    go(3'h5, 2'h0);
    wait_idle();
    chk("bad op", k, n_cmd);
    $display("test smart flush done");

    err_req <= 1'b1;
    go(OP_IDENTIFY, 2'h1);
    wait_idle();
    err_req <= 1'b0;
    chk("err", 32'h5, {29'h0, st[STS_ERR], st[25:24]});
    apb(1'b0, OFF_ERRTYPE, 32'h0);
    chk("err type", 32'h0000_0100, rd);
    apb(1'b0, 16'h0f00, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    $display("test error done");

    go(OP_SHUTDOWN, 2'h0);
    wait_idle();
    chk("count one", 32'h1, {28'h0, st[19:16]});
    go(OP_SHUTDOWN, 2'h1);
    wait_idle();
    chk("count zero", 32'h0, {28'h0, st[19:16]});
    k = n_cmd;
    go(OP_IDENTIFY, 2'h1);
    wait_idle();
    chk("inactive", k, n_cmd);
    $display("test shutdown done");
    finish_test();
  end
endmodule : testbench
